// ==== hw/fbiu_top.sv ====
// fifo buffer instruction unit: spi opcodes for rx/tx fifo and rx move
// How it works
// (RL1) read-and-copy returns the rx fifo byte count on byte two.
// (RL2) host must not read the rx fifo while a move is running.
// (RL3) tx write appends each data byte to the tx fifo tail in order while the fifo is not full.
// (RL4) each tx write data byte returns the fill count before storing it.
// (RL5) tx write into a full tx fifo raises the overflow pulse.
// (RL6) random opcode returns noise-fed lfsr bytes, one per spi byte.
// (RL7) move takes 12-bit address and 8-bit count, writes oldest bytes out.
// (RL8) move priority bit zero selects low slot, one selects high slot.
// (RL9) rx fifo empty before count done raises timeout, per wait bit.
// (RL10) bytes still left after a timeout are readable as status.
// (RL11) high move with wait bit set raises dpu hold and stalls the low slot; spi frames still run.
// (RL12) every finished move pulses the done flag of its priority.
// (RL13) a move to an already busy priority is refused with a fault.
// (RL14) each rx read data byte returns and removes the oldest byte.
// (RL15) read-and-copy also writes each byte to memory from an address.
// (RL16) the first byte of every frame returns the status byte.
`timescale 1ns/10ps
module fbiu_top import fbiu_pkg::*; (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	// spi pins
	input wire logic spi_sclk,
	input wire logic spi_csn_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	// rx fifo
	input wire logic [7:0] rx_data,
	input wire logic [7:0] rx_count,
	input wire logic rx_empty,
	output logic rx_pop,
	// tx fifo
	input wire logic [7:0] tx_count,
	input wire logic tx_full,
	output logic tx_push,
	output logic [7:0] tx_wdata,
	// memory write port
	output logic mem_we,
	output logic [11:0] mem_addr,
	output logic [7:0] mem_wdata,
	// receiver and control
	input wire logic noise_bit,
	input wire logic frame_busy,
	input wire logic move_wait_frame_bit,
	// status
	output logic [7:0] move_left,
	output logic dpu_hold,
	// exception pulses
	output logic tx_overflow,
	output logic move_drain_timeout,
	output logic priority_busy_fault,
	output logic low_prio_done,
	output logic high_prio_done
);
	fbiu_byte_if bif();
	fbiu_op_t op_reg, op_next;
	logic [3:0] idx_reg, idx_next;
	logic [11:0] cadr_reg, cadr_next, stg_reg, stg_next;
	logic sp_reg, sp_next;
	logic [1:0] act_reg, act_next, done_reg, done_next;
	logic [1:0][11:0] sadr_reg, sadr_next;
	logic [1:0][7:0] scnt_reg, scnt_next;
	logic [7:0] left_reg, left_next, twd_reg, twd_next, mdat_reg, mdat_next;
	logic [11:0] madr_reg, madr_next;
	logic pop_reg, pop_next, we_reg, we_next, push_reg, push_next;
	logic ovf_reg, ovf_next, tmo_reg, tmo_next, busy_reg, busy_next;
	logic hold_reg, hold_next, spi_take, launch, mv_s, data_byte;
	logic tk_reg, tk_next;
	logic [15:0] lfsr_reg, lfsr_next;
	logic [7:0] status;

	fbiu_spi u_spi (
		.clk(clk),
		.sys_rst(sys_rst),
		.spi_sclk(spi_sclk),
		.spi_csn_n(spi_csn_n),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.spi_miso_oe_n(spi_miso_oe_n),
		.bif(bif)
	);

	function automatic fbiu_op_t decode(input logic [7:0] b);
		case (b)
			OP_RX_READ: decode = FB_READ;
			OP_RX_COPY: decode = FB_COPY;
			OP_TX_WRITE: decode = FB_TXW;
			OP_RANDOM: decode = FB_RANDOM;
			OP_RX_MOVE: decode = FB_MOVE;
			default: decode = FB_NONE;
		endcase
	endfunction

	// noise keeps stirring the lfsr so bytes never repeat a fixed cycle
	always_comb begin
		lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
			lfsr_reg[12] ^ lfsr_reg[10] ^ noise_bit}; // RL6
	end

	// answer byte for the byte that is about to be shifted out
	always_comb begin
		status = 8'h00;
		status[ST_HOLD] = hold_reg;
		status[ST_HIGH] = act_reg[1];
		status[ST_LOW] = act_reg[0];
		status[ST_TXFULL] = tx_full;
		status[ST_RXEMPTY] = rx_empty;
		data_byte = 1'b0;
		bif.tx_byte = status; // RL16
		if (idx_reg != IDX_STATUS) begin
			case (op_reg)
				FB_READ: begin
					bif.tx_byte = rx_data; // RL14
					data_byte = 1'b1;
				end
				FB_COPY: begin
					if (idx_reg == IDX_ARG1) begin
						bif.tx_byte = rx_count; // RL1
					end else if (idx_reg >= IDX_ARG3) begin
						bif.tx_byte = rx_data;
						data_byte = 1'b1;
					end else begin
						bif.tx_byte = 8'h00;
					end
				end
				FB_TXW: bif.tx_byte = tx_count; // RL4
				FB_RANDOM: bif.tx_byte = lfsr_reg[7:0]; // RL6
				FB_MOVE: bif.tx_byte = rx_count;
				default: bif.tx_byte = 8'h00;
			endcase
		end
	end

	// frame decode, fifo access and the two-slot move engine
	always_comb begin
		op_next = op_reg;
		idx_next = idx_reg;
		cadr_next = cadr_reg;
		stg_next = stg_reg;
		sp_next = sp_reg;
		act_next = act_reg;
		sadr_next = sadr_reg;
		scnt_next = scnt_reg;
		left_next = left_reg;
		twd_next = twd_reg;
		madr_next = madr_reg;
		mdat_next = mdat_reg;
		tk_next = tk_reg;
		pop_next = 1'b0;
		we_next = 1'b0;
		push_next = 1'b0;
		ovf_next = 1'b0;
		tmo_next = 1'b0;
		busy_next = 1'b0;
		done_next = 2'b00;
		hold_next = act_reg[1] & move_wait_frame_bit; // RL11
		spi_take = 1'b0;
		launch = 1'b0;
		mv_s = act_reg[1];
		if (!bif.sel) begin
			idx_next = IDX_STATUS;
			op_next = FB_NONE;
			tk_next = 1'b0;
		end
		if (bif.rx_valid) begin
			if (idx_reg != IDX_MAX)
				idx_next = idx_reg + 4'h1;
			if (idx_reg == IDX_STATUS) begin
				op_next = decode(bif.rx_byte);
			end else begin
				case (op_reg)
					FB_TXW: begin
						if (tx_full) begin
							ovf_next = 1'b1; // RL5
						end else begin
							push_next = 1'b1; // RL3
							twd_next = bif.rx_byte;
						end
					end
					FB_COPY: begin
						if (idx_reg == IDX_ARG1)
							cadr_next[11:8] = bif.rx_byte[3:0]; // RL15
						if (idx_reg == IDX_ARG2)
							cadr_next[7:0] = bif.rx_byte;
					end
					FB_MOVE: begin
						if (idx_reg == IDX_ARG1) begin
							sp_next = bif.rx_byte[PRIO_BIT]; // RL8
							stg_next[11:8] = bif.rx_byte[3:0]; // RL7
						end
						if (idx_reg == IDX_ARG2)
							stg_next[7:0] = bif.rx_byte;
						if (idx_reg == IDX_ARG3)
							launch = 1'b1;
					end
					default: ;
				endcase
			end
		end
		if (launch) begin
			if (act_reg[sp_reg]) begin
				busy_next = 1'b1; // RL13
			end else begin
				act_next[sp_reg] = 1'b1; // RL8
				sadr_next[sp_reg] = stg_reg;
				scnt_next[sp_reg] = bif.rx_byte; // RL7
			end
		end
		// a pop needs one cycle before the fifo flags are trusted again
		if (bif.byte_start)
			tk_next = data_byte && !rx_empty && !pop_reg;
		// the head leaves only once its byte was clocked out, so the byte
		// preloaded after the last transfer of a frame is not lost
		if (bif.rx_valid && tk_reg) begin
			tk_next = 1'b0;
			pop_next = 1'b1; // RL14
			spi_take = 1'b1;
			if (op_reg == FB_COPY) begin
				we_next = 1'b1; // RL15
				madr_next = cadr_reg;
				mdat_next = rx_data;
				cadr_next = cadr_reg + 12'h001;
			end
		end
		// high slot always served first, so a waiting high move stalls low
		if (act_reg != 2'b00 && !spi_take && !pop_reg) begin
			if (scnt_reg[mv_s] == 8'h00) begin
				done_next[mv_s] = 1'b1; // RL12
				act_next[mv_s] = 1'b0;
			end else if (!rx_empty) begin
				pop_next = 1'b1; // RL7
				we_next = 1'b1;
				madr_next = sadr_reg[mv_s];
				mdat_next = rx_data;
				sadr_next[mv_s] = sadr_reg[mv_s] + 12'h001;
				scnt_next[mv_s] = scnt_reg[mv_s] - 8'h01;
			end else if (!move_wait_frame_bit || !frame_busy) begin
				tmo_next = 1'b1; // RL9
				done_next[mv_s] = 1'b1; // RL12
				act_next[mv_s] = 1'b0;
				left_next = scnt_reg[mv_s]; // RL10
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_reg <= FB_NONE;
			idx_reg <= IDX_STATUS;
			cadr_reg <= 12'h000;
			stg_reg <= 12'h000;
			sp_reg <= 1'b0;
			act_reg <= 2'b00;
			sadr_reg <= '0;
			scnt_reg <= '0;
			left_reg <= 8'h00;
			twd_reg <= 8'h00;
			madr_reg <= 12'h000;
			mdat_reg <= 8'h00;
			pop_reg <= 1'b0;
			we_reg <= 1'b0;
			push_reg <= 1'b0;
			ovf_reg <= 1'b0;
			tmo_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 2'b00;
			hold_reg <= 1'b0;
			tk_reg <= 1'b0;
			lfsr_reg <= LFSR_SEED;
		end else begin
			op_reg <= op_next;
			idx_reg <= idx_next;
			cadr_reg <= cadr_next;
			stg_reg <= stg_next;
			sp_reg <= sp_next;
			act_reg <= act_next;
			sadr_reg <= sadr_next;
			scnt_reg <= scnt_next;
			left_reg <= left_next;
			twd_reg <= twd_next;
			madr_reg <= madr_next;
			mdat_reg <= mdat_next;
			pop_reg <= pop_next;
			we_reg <= we_next;
			push_reg <= push_next;
			ovf_reg <= ovf_next;
			tmo_reg <= tmo_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			hold_reg <= hold_next;
			tk_reg <= tk_next;
			lfsr_reg <= lfsr_next;
		end
	end

	assign rx_pop = pop_reg;
	assign tx_push = push_reg;
	assign tx_wdata = twd_reg;
	assign mem_we = we_reg;
	assign mem_addr = madr_reg;
	assign mem_wdata = mdat_reg;
	assign move_left = left_reg;
	assign dpu_hold = hold_reg;
	assign tx_overflow = ovf_reg;
	assign move_drain_timeout = tmo_reg;
	assign priority_busy_fault = busy_reg;
	assign low_prio_done = done_reg[0];
	assign high_prio_done = done_reg[1];

	// checks of the documented behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_mv_go;
		act_reg != 2'b00 && !spi_take && !pop_reg &&
			scnt_reg[mv_s] != 8'h00 && !rx_empty;
	endsequence
	sequence s_mv_store;
		pop_reg && we_reg && mdat_reg == $past(rx_data);
	endsequence
	property p_rl1;
		bif.byte_start && op_reg == FB_COPY && idx_reg == IDX_ARG1
			|-> bif.tx_byte == rx_count;
	endproperty
	a_rl1: assert property (p_rl1) else $error("copy count wrong"); // RL1
	property p_rl3;
		bif.rx_valid && op_reg == FB_TXW && idx_reg != IDX_STATUS &&
			!tx_full |=> push_reg && twd_reg == $past(bif.rx_byte);
	endproperty
	a_rl3: assert property (p_rl3) else $error("tx byte lost"); // RL3
	property p_rl4;
		bif.byte_start && op_reg == FB_TXW && idx_reg != IDX_STATUS
			|-> bif.tx_byte == tx_count;
	endproperty
	a_rl4: assert property (p_rl4) else $error("tx count wrong"); // RL4
	property p_rl5;
		bif.rx_valid && op_reg == FB_TXW && idx_reg != IDX_STATUS &&
			tx_full |=> ovf_reg && !push_reg;
	endproperty
	a_rl5: assert property (p_rl5) else $error("no overflow"); // RL5
	property p_rl7;
		s_mv_go |=> s_mv_store;
	endproperty
	a_rl7: assert property (p_rl7) else $error("move step lost"); // RL7
	property p_rl8;
		launch && !act_reg[sp_reg] |=> act_reg[$past(sp_reg)];
	endproperty
	a_rl8: assert property (p_rl8) else $error("wrong slot"); // RL8
	property p_rl10;
		tmo_reg |-> left_reg == $past(scnt_reg[mv_s]) &&
			done_reg != 2'b00;
	endproperty
	a_rl10: assert property (p_rl10) else $error("left lost"); // RL10
	property p_rl11;
		act_reg[1] && move_wait_frame_bit |=> hold_reg &&
			(!$past(act_reg[0]) || $stable(scnt_reg[0]) && !done_reg[0]);
	endproperty
	a_rl11: assert property (p_rl11) else $error("low ran"); // RL11
	property p_rl12;
		$fell(act_reg[0]) |-> done_reg[0] && !done_reg[1];
	endproperty
	a_rl12: assert property (p_rl12) else $error("no done"); // RL12
	property p_rl13;
		launch && act_reg[sp_reg] |=> busy_reg &&
			($stable(act_reg) || done_reg != 2'b00);
	endproperty
	a_rl13: assert property (p_rl13) else $error("no busy"); // RL13
	property p_rl15;
		bif.rx_valid && tk_reg && op_reg == FB_COPY |=> we_reg && pop_reg &&
			madr_reg == $past(cadr_reg) && mdat_reg == $past(rx_data);
	endproperty
	a_rl15: assert property (p_rl15) else $error("copy miss"); // RL15
	property p_rl16;
		bif.byte_start && idx_reg == IDX_STATUS |-> bif.tx_byte == status;
	endproperty
	a_rl16: assert property (p_rl16) else $error("no status"); // RL16
endmodule // fbiu_top

// ==== hw/fbiu_pkg.sv ====
// shared constants and types of the fifo buffer instruction unit
package fbiu_pkg;
	// opcode encoding, arbitrary values
	localparam logic [7:0] OP_RX_READ = 8'h30;
	localparam logic [7:0] OP_RX_COPY = 8'h32;
	localparam logic [7:0] OP_TX_WRITE = 8'h3A;
	localparam logic [7:0] OP_RANDOM = 8'h3C;
	localparam logic [7:0] OP_RX_MOVE = 8'h54;
	// byte positions inside one chip-select frame
	localparam logic [3:0] IDX_STATUS = 4'h0;
	localparam logic [3:0] IDX_ARG1 = 4'h1;
	localparam logic [3:0] IDX_ARG2 = 4'h2;
	localparam logic [3:0] IDX_ARG3 = 4'h3;
	localparam logic [3:0] IDX_MAX = 4'hF;
	// status byte field positions
	localparam int ST_HOLD = 7;
	localparam int ST_HIGH = 6;
	localparam int ST_LOW = 5;
	localparam int ST_TXFULL = 4;
	localparam int ST_RXEMPTY = 3;
	// priority flag inside the first move operand byte
	localparam int PRIO_BIT = 7;
	// pin order {mosi, csn_n, sclk}; idle levels used at reset
	localparam logic [2:0] PIN_IDLE = 3'h2;
	localparam int SYNC_N = 3;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	typedef enum logic [2:0] {
		FB_NONE, FB_READ, FB_COPY, FB_TXW, FB_RANDOM, FB_MOVE
	} fbiu_op_t;
endpackage

// ==== hw/fbiu_byte_if.sv ====
// byte level link between the spi shifter and the instruction logic
`timescale 1ns/10ps
interface fbiu_byte_if;
	logic sel;
	logic byte_start;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	modport shifter(output sel, byte_start, rx_valid, rx_byte,
		input tx_byte);
	modport ctrl(input sel, byte_start, rx_valid, rx_byte,
		output tx_byte);
endinterface

// ==== hw/fbiu_spi.sv ====
// spi mode 0 byte shifter with pin synchronisers
`timescale 1ns/10ps
module fbiu_spi import fbiu_pkg::*; (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	// pins
	input wire logic spi_sclk,
	input wire logic spi_csn_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	// byte side
	fbiu_byte_if.shifter bif
);
	logic [2:0] pin_in;
	logic [2:0][SYNC_N-1:0] sy_reg, sy_next;
	logic [2:0] flt_reg, flt_next;
	logic [7:0] sh_reg, sh_next, in_reg, in_next, rxb_reg, rxb_next;
	logic [2:0] bit_reg, bit_next;
	logic miso_reg, miso_next, oe_n_reg, oe_n_next, val_reg, val_next;
	logic start;

	assign pin_in = {spi_mosi, spi_csn_n, spi_sclk};

	// three stage sync; a level counts once stages two and three agree
	for (genvar g = 0; g < 3; g++) begin : g_sync
		always_comb begin
			sy_next[g] = {sy_reg[g][SYNC_N-2:0], pin_in[g]};
			flt_next[g] = (sy_reg[g][1] == sy_reg[g][2]) ?
				sy_reg[g][2] : flt_reg[g];
		end
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				sy_reg[g] <= {SYNC_N{PIN_IDLE[g]}};
				flt_reg[g] <= PIN_IDLE[g];
			end else begin
				sy_reg[g] <= sy_next[g];
				flt_reg[g] <= flt_next[g];
			end
		end
	end

	// shift engine; sclk must be slow against clk for the sync delay
	always_comb begin
		sh_next = sh_reg;
		in_next = in_reg;
		rxb_next = rxb_reg;
		bit_next = bit_reg;
		miso_next = miso_reg;
		oe_n_next = oe_n_reg;
		val_next = 1'b0;
		start = 1'b0;
		if (flt_reg[1] && !flt_next[1]) begin
			// select falls: first answer bit must be out before sclk rises
			sh_next = bif.tx_byte;
			miso_next = bif.tx_byte[7];
			bit_next = 3'h0;
			oe_n_next = 1'b0;
			start = 1'b1;
		end else if (flt_next[1]) begin
			oe_n_next = 1'b1;
			bit_next = 3'h0;
		end else if (!flt_reg[0] && flt_next[0]) begin
			in_next = {in_reg[6:0], flt_reg[2]};
			bit_next = bit_reg + 3'h1;
			if (bit_reg == 3'h7) begin
				rxb_next = {in_reg[6:0], flt_reg[2]};
				val_next = 1'b1;
			end
		end else if (flt_reg[0] && !flt_next[0]) begin
			if (bit_reg == 3'h0) begin
				sh_next = bif.tx_byte;
				miso_next = bif.tx_byte[7];
				start = 1'b1;
			end else begin
				sh_next = {sh_reg[6:0], 1'b0};
				miso_next = sh_reg[6];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sh_reg <= 8'h00;
			in_reg <= 8'h00;
			rxb_reg <= 8'h00;
			bit_reg <= 3'h0;
			miso_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			val_reg <= 1'b0;
		end else begin
			sh_reg <= sh_next;
			in_reg <= in_next;
			rxb_reg <= rxb_next;
			bit_reg <= bit_next;
			miso_reg <= miso_next;
			oe_n_reg <= oe_n_next;
			val_reg <= val_next;
		end
	end

	// start is combinational so the loaded byte and its side effects agree
	assign bif.byte_start = start;
	assign bif.sel = !flt_reg[1];
	assign bif.rx_valid = val_reg;
	assign bif.rx_byte = rxb_reg;
	assign spi_miso = miso_reg;
	assign spi_miso_oe_n = oe_n_reg;
endmodule // fbiu_spi

// ==== testbench/fbiu_host.sv ====
// host side spi master model for the fifo buffer instruction unit
`timescale 1ns/10ps
module fbiu_host (
	// system
	input wire logic clk,
	// spi pins
	output logic spi_sclk,
	output logic spi_csn_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe_n
);
	// idle levels from time zero; sclk stands still outside frames
	initial begin
		spi_sclk = 1'b0;
		spi_csn_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// every phase spans at least 9 clk so the pin synchronisers keep up
	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic start();
		spi_csn_n = 1'b0;
		gap(10);
	endtask
	task automatic stop();
		gap(9);
		spi_csn_n = 1'b1;
		spi_mosi = ~spi_mosi; // released line must not show a stale bit
		gap(10);
	endtask
	// one byte msb first: data changes on the fall, read on the rise
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = b[i];
			gap(9);
			spi_sclk = 1'b1;
			r[i] = (spi_miso_oe_n === 1'b0) ? spi_miso : 1'bx;
			gap(9);
			spi_sclk = 1'b0;
		end
	endtask
endmodule // fbiu_host

// ==== testbench/tb_top.sv ====
// self-checking bench of the fifo buffer instruction unit
`timescale 1ns/10ps
module tb_top;
	import fbiu_pkg::*;
	typedef struct {
		logic [7:0] op;
		logic [7:0] arg;
		int pre;
		logic [7:0] exp;
	} fbiu_row_t;
	logic clk, sys_rst, spi_sclk, spi_csn_n, spi_mosi, spi_miso;
	logic spi_miso_oe_n, rx_empty, rx_pop, tx_full, tx_push, mem_we;
	logic noise_bit, frame_busy, move_wait_frame_bit, dpu_hold;
	logic tx_overflow, move_drain_timeout, priority_busy_fault;
	logic low_prio_done, high_prio_done;
	logic [7:0] rx_data, rx_count, tx_count, tx_wdata, mem_wdata;
	logic [7:0] move_left, s;
	logic [11:0] mem_addr;
	logic [7:0] mem [4096];
	logic [7:0] rx_q [$];
	logic [7:0] tx_q [$];
	logic [7:0] ob [8];
	logic [7:0] ib [8];
	logic [4:0] pv;
	int n_ev [5]; // high done, low done, fault, timeout, overflow
	int mismatches, n_checks, cyc;
	fbiu_row_t rows [5] = '{
		'{OP_RX_READ, 8'h00, 2, 8'hA0},
		'{OP_RX_COPY, 8'h01, 3, 8'h03},
		'{OP_TX_WRITE, 8'h55, 0, 8'h00},
		'{OP_RX_MOVE, 8'h00, 5, 8'h05},
		'{8'h00, 8'h00, 1, 8'h00}
	};

	fbiu_top i_fbiu_top (.clk(clk), .sys_rst(sys_rst),
		.spi_sclk(spi_sclk), .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
		.rx_data(rx_data), .rx_count(rx_count), .rx_empty(rx_empty),
		.rx_pop(rx_pop), .tx_count(tx_count), .tx_full(tx_full),
		.tx_push(tx_push), .tx_wdata(tx_wdata), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .noise_bit(noise_bit),
		.frame_busy(frame_busy),
		.move_wait_frame_bit(move_wait_frame_bit),
		.move_left(move_left), .dpu_hold(dpu_hold),
		.tx_overflow(tx_overflow),
		.move_drain_timeout(move_drain_timeout),
		.priority_busy_fault(priority_busy_fault),
		.low_prio_done(low_prio_done), .high_prio_done(high_prio_done));
	fbiu_host i_fbiu_host (.clk(clk), .spi_sclk(spi_sclk),
		.spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe_n(spi_miso_oe_n));

	// clock at 200 MHz
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// fifos and memory; pulses are one cycle wide so each fall sees one
	always @(negedge clk) begin
		cyc++;
		noise_bit = cyc[0] ^ cyc[3];
		if (rx_pop === 1'b1) void'(rx_q.pop_front());
		if (tx_push === 1'b1) tx_q.push_back(tx_wdata);
		if (mem_we === 1'b1) mem[mem_addr] = mem_wdata;
		pv = {tx_overflow, move_drain_timeout, priority_busy_fault,
			low_prio_done, high_prio_done};
		foreach (n_ev[k]) if (pv[k] === 1'b1) n_ev[k]++;
		rx_count = 8'(rx_q.size());
		rx_empty = (rx_q.size() == 0);
		rx_data = rx_empty ? ~rx_data : rx_q[0]; // empty head is junk
		tx_count = 8'(tx_q.size());
		tx_full = (tx_q.size() >= 2); // shallow tx fifo to reach full
	end

	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	// empty fifos, preload n rx bytes A0, A1, ..., clear event counts
	task automatic load(input int n);
		rx_q.delete();
		tx_q.delete();
		for (int k = 0; k < n; k++) rx_q.push_back(8'hA0 + 8'(k));
		repeat (2) @(negedge clk);
		foreach (n_ev[k]) n_ev[k] = 0;
	endtask
	task automatic set4(input logic [7:0] a, b, c, d);
		ob[0] = a;
		ob[1] = b;
		ob[2] = c;
		ob[3] = d;
	endtask
	task automatic frame(input int n);
		i_fbiu_host.start();
		for (int k = 0; k < n; k++) i_fbiu_host.xfer(ob[k], ib[k]);
		i_fbiu_host.stop();
		repeat (30) @(negedge clk); // let background moves settle
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// watchdog: the run needs about 40 us, so 300 us means a hang
	initial begin
		#300_000;
		mismatches++;
		conclude();
	end

	initial begin
		sys_rst = 1'b1;
		frame_busy = 1'b0;
		move_wait_frame_bit = 1'b0;
		rx_data = 8'h00;
		noise_bit = 1'b0;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		repeat (5) @(negedge clk);
		chk(8'h01, {7'h00, spi_miso_oe_n});
		chk(8'h00, {7'h00, dpu_hold});
		chk(8'h00, move_left);
		$display("test reset done");
		// table: status on byte 0, then the first answer byte
		foreach (rows[r]) begin
			load(rows[r].pre);
			ob[0] = rows[r].op;
			ob[1] = rows[r].arg;
			s = {3'h0, tx_q.size() >= 2, rx_q.size() == 0, 3'h0};
			frame(2);
			chk(s, ib[0]);
			chk(rows[r].exp, ib[1]);
		end
		$display("test table done");
		// tx write runs into a full fifo
		load(0);
		set4(OP_TX_WRITE, 8'h11, 8'h22, 8'h33);
		frame(4);
		chk(8'h01, ib[2]);
		chk(8'h02, ib[3]);
		chk(8'h11, tx_q[0]);
		chk(8'h22, tx_q[1]);
		chk(8'h01, 8'(n_ev[4]));
		$display("test tx write done");
		// read-and-copy to 0x123; host keeps it apart from moves
		// the byte preloaded after the last transfer must stay queued
		load(3);
		set4(OP_RX_COPY, 8'h01, 8'h23, 8'h00);
		ob[4] = 8'h00;
		frame(5);
		chk(8'h03, ib[1]);
		chk(8'hA0, ib[3]);
		chk(8'hA1, ib[4]);
		chk(8'hA0, mem[12'h123]);
		chk(8'hA1, mem[12'h124]);
		chk(8'hA2, rx_q[0]);
		$display("test copy done");
		// random bytes must not be the same in all three answer bytes
		set4(OP_RANDOM, 8'h00, 8'h00, 8'h00);
		frame(4);
		chk(8'h01, {7'h00, ib[1] != ib[2] || ib[2] != ib[3]});
		$display("test random done");
		// low move of two bytes to 0x200
		load(3);
		set4(OP_RX_MOVE, 8'h02, 8'h00, 8'h02);
		frame(4);
		chk(8'h03, ib[1]);
		chk(8'hA0, mem[12'h200]);
		chk(8'hA1, mem[12'h201]);
		chk(8'hA2, rx_q[0]);
		chk(8'h01, 8'(n_ev[1]));
		$display("test low move done");
		// move of three with one byte present times out
		load(1);
		set4(OP_RX_MOVE, 8'h03, 8'h00, 8'h03);
		frame(4);
		chk(8'hA0, mem[12'h300]);
		chk(8'h01, 8'(n_ev[3]));
		chk(8'h02, move_left);
		chk(8'h01, 8'(n_ev[1]));
		$display("test timeout done");
		// high move waits for the frame and holds the unit
		load(0);
		move_wait_frame_bit = 1'b1;
		frame_busy = 1'b1;
		set4(OP_RX_MOVE, 8'h84, 8'h00, 8'h04);
		frame(4);
		chk(8'h01, {7'h00, dpu_hold});
		ob[0] = 8'h00;
		frame(1);
		chk(8'hC8, ib[0]);
		set4(OP_RX_MOVE, 8'h84, 8'h00, 8'h04);
		frame(4);
		chk(8'h01, 8'(n_ev[2]));
		// an empty low move would finish at once unless it is held
		set4(OP_RX_MOVE, 8'h00, 8'h00, 8'h00);
		frame(4);
		chk(8'h00, 8'(n_ev[1]));
		frame_busy = 1'b0;
		repeat (10) @(negedge clk);
		chk(8'h01, 8'(n_ev[3]));
		chk(8'h01, 8'(n_ev[0]));
		chk(8'h01, 8'(n_ev[1]));
		chk(8'h04, move_left);
		chk(8'h00, {7'h00, dpu_hold});
		$display("test high move done");
		// reset in mid-run drops a waiting high move
		frame_busy = 1'b1;
		set4(OP_RX_MOVE, 8'h84, 8'h00, 8'h04);
		frame(4);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		repeat (5) @(negedge clk);
		chk(8'h00, {7'h00, dpu_hold});
		chk(8'h00, move_left);
		ob[0] = 8'h00;
		frame(1);
		chk(8'h08, ib[0]);
		$display("test reset in run done");
		conclude();
	end
endmodule // tb_top
